//--- rcps_map.svh
/*
  offsets-free constant map for the reset and clock pin select block:
  port modes, reset values and counts.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef RCPS_MAP_SVH
`define RCPS_MAP_SVH

// ----------------------------------------
// port output modes (two bits per pin)
// ----------------------------------------
`define RCPS_MODE_QUASI     2'h0
`define RCPS_MODE_PUSHPULL  2'h1
`define RCPS_MODE_INPUT     2'h2
`define RCPS_MODE_OPENDRAIN 2'h3

// ----------------------------------------
// field positions, reset values and counts
// ----------------------------------------
`define RCPS_PIN0           0
`define RCPS_PIN1           1
`define RCPS_MODE_RST       4'hA
`define RCPS_RESET_VECTOR   16'h0000
`define RCPS_CLKDIV         2
`define RCPS_ISP_EDGES      3'h3
`define RCPS_ISP_CNT_MAX    3'h7

`endif

//--- rcps_pkg.sv
/*
  types for the reset and clock pin select block.
  assumes rcps_map.svh is on the include path.
*/
package rcps_pkg;
  `include "rcps_map.svh"

  // cpu clock source as chosen by the nonvolatile configuration
  typedef enum logic [1:0] {
    RCPS_SRC_RC     = 2'h0,
    RCPS_SRC_WDOG   = 2'h1,
    RCPS_SRC_EXTCLK = 2'h2,
    RCPS_SRC_XTAL   = 2'h3
  } rcps_clk_src_t;

  typedef logic [1:0] rcps_mode_t;
endpackage

//--- rcps_pin_if.sv
/*
  carrier between the top and the reset pin conditioner.
  assumes one clock domain, the cpu clock.
*/
`timescale 1ns/1ns
interface rcps_pin_if;
  logic pin_level;   // filtered level of the shared reset pin
  logic por_active;  // power-on sequence in progress
  logic isp_req;     // programming entry caught at power-on

  modport cond (output pin_level, output isp_req, input por_active);
  modport top  (input pin_level, input isp_req, output por_active);
endinterface

//--- rcps_rst_cond.sv
/*
  reset pin conditioner: three-stage synchroniser with agreement filter,
  and the power-on programming entry detector.
  assumes the raw pin is asynchronous to CLK.
*/
`timescale 1ns/1ns
`include "rcps_map.svh"
module rcps_rst_cond
  import rcps_pkg::*;
(
  input  wire logic  CLK,
  input  wire logic  RST_B,
  input  wire logic  CE,
  input  wire logic  PIN_RAW,
  rcps_pin_if.cond   pif
);
  import rcps_pkg::*;

  logic [2:0] sync_ff;
  logic [2:0] nxt_sync;
  logic       level_ff;
  logic       nxt_level;
  logic [2:0] edge_cnt_ff;
  logic [2:0] nxt_edge_cnt;
  logic       por_d_ff;
  logic       nxt_por_d;
  logic       isp_ff;
  logic       nxt_isp;

  // ----------------------------------------
  // synchroniser and filter
  // ----------------------------------------
  // change taken only once stages two and three agree
  always_comb begin
    nxt_sync  = {sync_ff[1:0], PIN_RAW};
    nxt_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sync_ff  <= 3'h7;
      level_ff <= 1'b1;
    end else if (CE) begin
      sync_ff  <= nxt_sync;
      level_ff <= nxt_level;
    end
  end

  // ----------------------------------------
  // programming entry
  // ----------------------------------------
  // count low pulses on the pin while power-on runs, decide at its end
  always_comb begin
    nxt_edge_cnt = edge_cnt_ff;
    nxt_isp      = isp_ff;
    nxt_por_d    = pif.por_active;
    if (pif.por_active && level_ff && !nxt_level &&
        edge_cnt_ff != `RCPS_ISP_CNT_MAX) begin
      nxt_edge_cnt = edge_cnt_ff + 3'h1;
    end
    if (por_d_ff && !pif.por_active) begin
      nxt_isp      = (edge_cnt_ff >= `RCPS_ISP_EDGES);
      nxt_edge_cnt = 3'h0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      edge_cnt_ff <= 3'h0;
      por_d_ff    <= 1'b0;
      isp_ff      <= 1'b0;
    end else if (CE) begin
      edge_cnt_ff <= nxt_edge_cnt;
      por_d_ff    <= nxt_por_d;
      isp_ff      <= nxt_isp;
    end
  end

  assign pif.pin_level = level_ff;
  assign pif.isp_req   = isp_ff;
endmodule

//--- rcps_top.sv
/*
  reset and clock pin select: shared reset/input pin, and the two port 3
  pins that double as oscillator pins or divided clock output.
  assumes CLK is the cpu clock, RST_B the system reset, and the
  configuration inputs are stable levels from the configuration logic.
*/
// Function
// - low on reset-function pin resets ports, peripherals; fetch restarts at zero.
// - shared pin is input only; reset at power-on or when configuration selects.
// - three or more pin pulses during power-on force programming mode entry at its end.
// - during reset port 3 latches are input only, pull-ups off.
// - each port 3 pin has its own output mode, behaviour follows it.
// - clock-out enable puts cpu clock divided by two on port 3 bit 0.
// - clock-out only for rc, watchdog or external clock, not crystal timer use.
// - crystal option makes port 3 bit 0 the amplifier output.
// - port 3 bit 1 is oscillator input unless rc/watchdog and no crystal timer.
`timescale 1ns/1ns
`include "rcps_map.svh"
module rcps_top
  import rcps_pkg::*;
(
  input  wire logic          CLK,
  input  wire logic          RST_B,
  input  wire logic          CE,
  input  wire logic          POR_ACTIVE,
  input  wire logic          RESET_PIN_RAW,
  input  wire logic          USER_CONFIG_RESET_EN,
  input  wire rcps_clk_src_t CLK_SRC,
  input  wire logic          TIMER_USES_XTAL,
  input  wire logic          CLOCK_OUT_ENABLE,
  input  wire logic [3:0]    PORT3_MODE,
  input  wire logic [1:0]    PORT3_LATCH,
  input  wire logic [1:0]    PORT3_PIN_IN,
  output logic      [1:0]    PORT3_PIN_OUT,
  output logic      [1:0]    PORT3_PIN_OE_B,
  output logic      [1:0]    PORT3_PULLUP_EN,
  output logic      [1:0]    PORT3_READ,
  output logic               PORT1_BIT5_INPUT,
  output logic               PIN_RESET_B,
  output logic               ISP_ENTRY,
  output logic      [15:0]   RESTART_ADDR,
  output logic               OSC_AMP_ENABLE,
  output logic               OSC_INPUT_SELECT
);
  import rcps_pkg::*;

  rcps_pin_if pif ();

  logic        pin_rst_ff;
  logic        nxt_pin_rst;
  logic [3:0]  mode_ff;
  logic [3:0]  nxt_mode;
  logic        div_ff;
  logic        nxt_div;
  logic [1:0]  out_ff;
  logic [1:0]  nxt_out;
  logic [1:0]  oe_b_ff;
  logic [1:0]  nxt_oe_b;
  logic [1:0]  pu_ff;
  logic [1:0]  nxt_pu;
  logic [1:0]  rd_ff;
  logic [1:0]  nxt_rd;
  logic [2:0]  s3_0_ff;
  logic [2:0]  s3_1_ff;
  logic [2:0]  nxt_s3_0;
  logic [2:0]  nxt_s3_1;
  logic        divided_clock_output_ok;
  logic        divided_clock_output_on;
  logic        p30_osc;
  logic        p31_osc;

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  // filtered level: stage three is taken once stages two and three agree,
  // so a single-cycle glitch on a pin never reaches the core
  function automatic logic sync_pick(input logic [2:0] stages, input logic held);
    logic pick;
    pick = held;
    if (stages[1] == stages[2]) begin
      pick = stages[2];
    end
    return pick;
  endfunction

  // ----------------------------------------
  // reset pin conditioning
  // ----------------------------------------
  assign pif.por_active = POR_ACTIVE;

  rcps_rst_cond u_cond (
    .CLK     (CLK),
    .RST_B   (RST_B),
    .CE      (CE),
    .PIN_RAW (RESET_PIN_RAW),
    .pif     (pif)
  );

  // pin resets only while power-on runs or the configuration selects it
  always_comb begin
    nxt_pin_rst = !pif.pin_level && (POR_ACTIVE || USER_CONFIG_RESET_EN);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_rst_ff <= 1'b0;
    end else if (CE) begin
      pin_rst_ff <= nxt_pin_rst;
    end
  end

  assign PIN_RESET_B      = !pin_rst_ff;
  assign RESTART_ADDR     = `RCPS_RESET_VECTOR;
  assign ISP_ENTRY        = pif.isp_req;
  assign PORT1_BIT5_INPUT = pif.pin_level;

  // ----------------------------------------
  // pin function selection
  // ----------------------------------------
  // clock-out needs a non-crystal source and crystal pins free of timer use
  always_comb begin
    divided_clock_output_ok = (CLK_SRC != RCPS_SRC_XTAL) && !TIMER_USES_XTAL;
    // clock-out held off during pin reset so the port stays input only
    divided_clock_output_on = CLOCK_OUT_ENABLE && divided_clock_output_ok && !pin_rst_ff;
    p30_osc   = (CLK_SRC == RCPS_SRC_XTAL) || TIMER_USES_XTAL;
    p31_osc   = !(((CLK_SRC == RCPS_SRC_RC) || (CLK_SRC == RCPS_SRC_WDOG)) &&
                  !TIMER_USES_XTAL);
  end

  assign OSC_AMP_ENABLE   = p30_osc;
  assign OSC_INPUT_SELECT = p31_osc;

  // ----------------------------------------
  // mode latches and clock divider
  // ----------------------------------------
  // modes forced to input only while any reset is active
  always_comb begin
    nxt_mode = pin_rst_ff ? `RCPS_MODE_RST : PORT3_MODE;
    nxt_div  = divided_clock_output_on ? !div_ff : 1'b0;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      mode_ff <= `RCPS_MODE_RST;
      div_ff  <= 1'b0;
    end else if (CE) begin
      mode_ff <= nxt_mode;
      div_ff  <= nxt_div;
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  // one pin's drive, pull-up and output value from its own mode
  // quasi mode: latch low drives low, latch high releases onto the pull-up
  function automatic logic [2:0] pin_drive(input rcps_mode_t mode, input logic latch);
    logic [2:0] r;  // {oe_b, pullup, out}
    r = {1'b1, 1'b0, 1'b1};
    case (mode)
      `RCPS_MODE_QUASI:     r = {latch, latch, 1'b0};
      `RCPS_MODE_PUSHPULL:  r = {1'b0, 1'b0, latch};
      `RCPS_MODE_INPUT:     r = {1'b1, 1'b0, 1'b1};
      `RCPS_MODE_OPENDRAIN: r = {latch, 1'b0, 1'b0};
      default:              r = {1'b1, 1'b0, 1'b1};
    endcase
    return r;
  endfunction

  always_comb begin
    logic [2:0] d0;
    logic [2:0] d1;
    d0 = pin_drive(mode_ff[1:0], PORT3_LATCH[`RCPS_PIN0]);
    d1 = pin_drive(mode_ff[3:2], PORT3_LATCH[`RCPS_PIN1]);
    if (divided_clock_output_on) begin
      d0 = {1'b0, 1'b0, nxt_div};
    end else if (p30_osc) begin
      d0 = {1'b1, 1'b0, 1'b1};
    end
    if (p31_osc) begin
      d1 = {1'b1, 1'b0, 1'b1};
    end
    nxt_oe_b = {d1[2], d0[2]};
    nxt_pu   = {d1[1], d0[1]};
    nxt_out  = {d1[0], d0[0]};
    nxt_rd   = {sync_pick(s3_1_ff, rd_ff[1]),
                sync_pick(s3_0_ff, rd_ff[0])};
  end

  // ----------------------------------------
  // port 3 input synchronisers
  // ----------------------------------------
  // pin levels are asynchronous to CLK, three stages before use
  always_comb begin
    nxt_s3_0 = {s3_0_ff[1:0], PORT3_PIN_IN[`RCPS_PIN0]};
    nxt_s3_1 = {s3_1_ff[1:0], PORT3_PIN_IN[`RCPS_PIN1]};
  end

  // pins released and pull-ups off during reset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_ff  <= 2'h3;
      oe_b_ff <= 2'h3;
      pu_ff   <= 2'h0;
      rd_ff   <= 2'h3;
      s3_0_ff <= 3'h7;
      s3_1_ff <= 3'h7;
    end else if (CE) begin
      out_ff  <= nxt_out;
      oe_b_ff <= nxt_oe_b;
      pu_ff   <= nxt_pu;
      rd_ff   <= nxt_rd;
      s3_0_ff <= nxt_s3_0;
      s3_1_ff <= nxt_s3_1;
    end
  end

  assign PORT3_PIN_OUT   = out_ff;
  assign PORT3_PIN_OE_B  = oe_b_ff;
  assign PORT3_PULLUP_EN = pu_ff;
  assign PORT3_READ      = rd_ff;
endmodule

//--- rcps_ext_model.sv
/*
  far-side model: external reset source and loads on the port 3 pins.
  assumes released pins float unless the weak pull-up is on.
*/
`timescale 1ns/1ns
module rcps_ext_model (
  input  wire logic       clk,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] oe_b,
  input  wire logic [1:0] pullup_en,
  output logic            rst_pin,
  output logic      [1:0] pin_in
);
  logic [1:0] flt = 2'h0;

  initial rst_pin = 1'b1;
  // floating level flips every cycle
  always @(posedge clk) flt <= ~flt;
  // wire level from both parties
  always_comb for (int i = 0; i < 2; i++) pin_in[i] = !oe_b[i] ? pin_out[i] : pullup_en[i] | flt[i];

  // reset pin held at a level
  task automatic set_pin(input logic lvl);
    @(posedge clk) rst_pin <= lvl;
  endtask

  // n low pulses, w cycles low and w+1 high between pulses
  task automatic pulse(input int n, input int w);
    repeat (n) begin
      @(posedge clk) rst_pin <= 1'b0;
      repeat (w) @(posedge clk);
      rst_pin <= 1'b1;
      repeat (w) @(posedge clk);
    end
  endtask
endmodule

//--- rcps_top_chk.sv
/*
  port checker for rcps_top.
  assumes CE held high, one clock domain.
*/
`timescale 1ns/1ns
module rcps_chk
  import rcps_pkg::*;
(
  input wire logic          CLK,
  input wire logic          RST_B,
  input wire logic          POR_ACTIVE,
  input wire logic          USER_CONFIG_RESET_EN,
  input wire rcps_clk_src_t CLK_SRC,
  input wire logic          TIMER_USES_XTAL,
  input wire logic          CLOCK_OUT_ENABLE,
  input wire logic [1:0]    PORT3_PIN_OUT,
  input wire logic [1:0]    PORT3_PIN_OE_B,
  input wire logic [1:0]    PORT3_PULLUP_EN,
  input wire logic          PORT1_BIT5_INPUT,
  input wire logic          PIN_RESET_B,
  input wire logic          ISP_ENTRY,
  input wire logic [15:0]   RESTART_ADDR,
  input wire logic          OSC_AMP_ENABLE,
  input wire logic          OSC_INPUT_SELECT
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // crystal use and clock-out conditions
  wire xtal = (CLK_SRC == RCPS_SRC_XTAL) || TIMER_USES_XTAL;
  wire co   = CLOCK_OUT_ENABLE && !xtal && PIN_RESET_B;

  a_release_idle: assert property ($rose(RST_B) |-> PORT3_PIN_OE_B == 2'h3 &&
    PORT3_PULLUP_EN == 2'h0) else $error("pins driven at reset release");
  a_pin_reset: assert property (!PORT1_BIT5_INPUT && (POR_ACTIVE || USER_CONFIG_RESET_EN)
    |=> !PIN_RESET_B) else $error("pin low gave no reset");
  a_pin_refused: assert property (!POR_ACTIVE && !USER_CONFIG_RESET_EN |=> PIN_RESET_B)
    else $error("reset from disabled pin");
  a_reset_mode: assert property (!PIN_RESET_B [*2] |=> PORT3_PIN_OE_B == 2'h3 &&
    PORT3_PULLUP_EN == 2'h0) else $error("port not input only in reset");
  a_restart_zero: assert property (RESTART_ADDR == 16'h0000)
    else $error("restart address not zero");
  a_divided_clock_output_run: assert property (co [*3] |-> !PORT3_PIN_OE_B[0] &&
    PORT3_PIN_OUT[0] != $past(PORT3_PIN_OUT[0])) else $error("clock out not toggling");
  a_xtal_owns: assert property (xtal [*3] |-> OSC_AMP_ENABLE && PORT3_PIN_OE_B[0] &&
    !PORT3_PULLUP_EN[0]) else $error("pin 0 not given to amplifier");
  a_osc_input: assert property (OSC_INPUT_SELECT == !((CLK_SRC == RCPS_SRC_RC ||
    CLK_SRC == RCPS_SRC_WDOG) && !TIMER_USES_XTAL)) else $error("pin 1 role wrong");
  a_in_released: assert property (OSC_INPUT_SELECT [*3] |-> PORT3_PIN_OE_B[1])
    else $error("oscillator input driven");
  a_isp_hold: assert property (ISP_ENTRY |=> ISP_ENTRY) else $error("entry flag dropped");
  a_isp_after: assert property ($rose(ISP_ENTRY) |-> !POR_ACTIVE)
    else $error("entry flag during power-on");

  // main scenarios reached
  c_isp: cover property (ISP_ENTRY);
  c_pin_rst: cover property (!PIN_RESET_B [*2]);
  c_divided_clock_output: cover property (co [*3]);
endmodule

bind rcps_top rcps_chk chk (.*);

//--- tb_rcps_top.sv
/*
  bench for rcps_top: drives configuration levels, checks pin roles.
  assumes rcps_ext_model as the far side and CE held high.
*/
`timescale 1ns/1ns
`include "rcps_map.svh"
module tb_rcps_top;
  import rcps_pkg::*;
  logic clk = 0, rst_b = 0, por = 1, ucfg = 0, tmr_x = 0, coe = 0, raw;
  rcps_clk_src_t src = RCPS_SRC_RC;
  logic [3:0]  mode = 4'hA;
  logic [1:0]  latch = 2'h3, pin_in, pin_out, oe_b, pu, rd;
  logic        p15, prst_b, isp, amp, osel;
  logic [15:0] raddr;
  int n_fail = 0, n_compared = 0;

  initial forever #10 clk = ~clk;

  rcps_top dut (.CLK(clk), .RST_B(rst_b), .CE(1'b1), .POR_ACTIVE(por), .RESET_PIN_RAW(raw),
    .USER_CONFIG_RESET_EN(ucfg), .CLK_SRC(src), .TIMER_USES_XTAL(tmr_x),
    .CLOCK_OUT_ENABLE(coe), .PORT3_MODE(mode), .PORT3_LATCH(latch), .PORT3_PIN_IN(pin_in),
    .PORT3_PIN_OUT(pin_out), .PORT3_PIN_OE_B(oe_b), .PORT3_PULLUP_EN(pu), .PORT3_READ(rd),
    .PORT1_BIT5_INPUT(p15), .PIN_RESET_B(prst_b), .ISP_ENTRY(isp), .RESTART_ADDR(raddr),
    .OSC_AMP_ENABLE(amp), .OSC_INPUT_SELECT(osel));
  rcps_ext_model ext (.clk(clk), .pin_out(pin_out), .oe_b(oe_b), .pullup_en(pu),
    .rst_pin(raw), .pin_in(pin_in));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask

  // bounded wait for the pin reset level
  task automatic wait_rst(input logic lvl);
    int k;
    for (k = 0; k < 20 && prst_b !== lvl; k++) @(negedge clk);
    if (k == 20) begin
      n_fail++;
      summarize();
    end
  endtask

  // main sequence
  initial begin
    logic b;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    tk(1);
    check(oe_b, 2'h3);
    check(pu, 2'h0);
    check(raddr, 16'h0000);
    ext.pulse(3, 4);
    tk(1);
    check(isp, 1'b0);
    @(posedge clk) por <= 1'b0;
    tk(3);
    check(isp, 1'b1);
    ext.set_pin(1'b0);
    tk(8);
    check(prst_b, 1'b1);
    check(p15, 1'b0);
    @(posedge clk) ucfg <= 1'b1;
    wait_rst(1'b0);
    tk(3);
    check(oe_b, 2'h3);
    check(pu, 2'h0);
    ext.set_pin(1'b1);
    wait_rst(1'b1);
    // every mode and latch value on pin 1, pin 0 push-pull high
    for (int m = 0; m < 4; m++)
      for (int l = 0; l < 2; l++) begin
        @(posedge clk);
        mode  <= {m[1:0], `RCPS_MODE_PUSHPULL};
        latch <= {l[0], 1'b1};
        tk(3);
        check(oe_b[1], (m == 2) || (l == 1 && m != 1));
        check({oe_b[0], pin_out[0]}, 2'h1);
        check(pu[1], m == 0 && l == 1);
        check(pin_out[1], (m == 2) || (m == 1 && l == 1));
      end
    // both pins push-pull, read path follows the driven levels
    @(posedge clk);
    mode  <= {`RCPS_MODE_PUSHPULL, `RCPS_MODE_PUSHPULL};
    latch <= 2'h1;
    tk(8);
    check(rd, 2'h1);
    @(posedge clk) coe <= 1'b1;
    tk(2);
    b = pin_out[0];
    tk(1);
    check({oe_b[0], pin_out[0]}, {1'b0, !b});
    // each clock source, clock out still requested
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) src <= rcps_clk_src_t'(s);
      tk(3);
      check(osel, s > 1);
      check(amp, s == 3);
      check(oe_b[0], s == 3);
    end
    @(posedge clk) src <= RCPS_SRC_RC;
    tmr_x <= 1'b1;
    tk(3);
    check({amp, osel, oe_b}, 4'hF);
    summarize();
  end
endmodule
